// ===== accel_defs.svh
// Register offsets, field positions, reset values and behaviour list for the accelerometer register bank.
//
// Behaviour
// - Reference register is eight bits wide and resets to zero.
// - All-axes overrun sets when a full new set overwrites an unread set.
// - Each axis overrun sets when its new sample overwrites its unread sample.
// - All-axes new-data flag rises only once a complete new set is ready.
// - Each axis has its own new-data flag for a fresh readable sample.
// - Each axis reads as a signed low/high byte pair.
// - Queue mode field resets to zero: bypass, fifo, stream, trigger.
// - Trigger-select bit picks first or second interrupt as trigger event.
// - Watermark flag is high when fill level exceeds the 5-bit threshold.
// - Queue overrun flags at 32 unread sets; next tick overwrites oldest in stream mode or before the trigger, fifo mode stops.
// - Queue overrun clears once the host reads the next sample set.
// - Empty flag is high when no unread sets remain.
// - Unread count rises per tick until full and falls per retrieved set.
// - Six enables, reset zero, allow the first interrupt per axis direction.
// - Combination and six-direction bits select OR, AND, movement or position.
// - Movement mode raises the interrupt on zone entry and holds it until the next output-rate tick.
// - Position mode holds the interrupt while orientation stays in a known zone.
// - Interrupt configuration loads at boot; host writes before boot end are ignored.
// - Queue operation is gated by an enable bit that resets to zero.
// - Byte order bit puts low or high byte at the lower address.
`ifndef ACCEL_DEFS_SVH
`define ACCEL_DEFS_SVH

`define REF_ADDR        8'h26
`define STATUS_ADDR     8'h27
`define X_LOW_ADDR      8'h28
`define X_HIGH_ADDR     8'h29
`define Y_LOW_ADDR      8'h2A
`define Y_HIGH_ADDR     8'h2B
`define Z_LOW_ADDR      8'h2C
`define Z_HIGH_ADDR     8'h2D
`define FCTRL_ADDR      8'h2E
`define FSRC_ADDR       8'h2F
`define INTCFG_ADDR     8'h30
`define CORE_CTRL_ADDR  8'h40

`define REF_RESET       8'h00
`define FCTRL_RESET     8'h00
`define INTCFG_RESET    8'h00
`define CORE_CTRL_RESET 8'h00

`define FM_MSB          7
`define FM_LSB          6
`define TR_BIT          5
`define FTH_MSB         4
`define AOI_BIT         7
`define SIXD_BIT        6
`define EN_MSB          5
`define FIFO_EN_BIT     0
`define BLE_BIT         1

`define QUEUE_DEPTH     6'h20
`define UNREAD_MAX      5'h1F

`endif

// ===== accel_pkg.sv
// Types shared by the accelerometer register bank.
package accel_pkg;
	typedef enum logic [1:0] {BYPASS, FIFO_STOP, STREAM, TRIGGER} queue_mode_e;
	typedef enum logic [1:0] {OR_COMB, SIX_MOVE, AND_COMB, SIX_POS} int_mode_e;
endpackage

// ===== accel_status_fifo_int_regs.sv
// Register bank with axis status, sample queue and first interrupt generator.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "accel_defs.svh"

module accel_status_fifo_int_regs (
	input  wire logic        clk,                  // 50 MHz clock
	input  wire logic        rst,                  // Synchronous reset, active high
	input  wire logic [7:0]  addr,                 // Register address
	input  wire logic [7:0]  wdata,                // Write data
	input  wire logic        wr,                   // Write strobe
	input  wire logic        rd,                   // Read strobe
	output logic      [7:0]  rdata,                // Read data, cycle after rd
	input  wire logic        odr_tick,             // Output data rate tick
	input  wire logic [2:0]  sample_we,            // Per-axis new sample strobe, bit0 X
	input  wire logic [15:0] x_sample,             // X sample
	input  wire logic [15:0] y_sample,             // Y sample
	input  wire logic [15:0] z_sample,             // Z sample
	input  wire logic [5:0]  axis_events,          // ZH ZL YH YL XH XL event levels
	input  wire logic        boot_done,            // Boot sequence finished
	input  wire logic [7:0]  boot_cfg,             // Interrupt configuration loaded at boot
	input  wire logic        second_interrupt_pin, // Second interrupt pin level
	output logic             first_interrupt_pin   // First interrupt output
);

	function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic hi);
		pick_byte = hi ? v[15:8] : v[7:0];
	endfunction

	function automatic logic [5:0] bump(input logic [5:0] c, input logic up, input logic dn);
		bump = c + {5'h00, up} - {5'h00, dn};
	endfunction

	logic [7:0]  reference_value;
	logic [7:0]  fifo_control;
	logic [7:0]  int_one_config;
	logic [7:0]  core_control;
	logic [15:0] axis_val [3];
	logic [2:0]  new_data;
	logic [2:0]  axis_overrun;
	logic        all_axes_overrun;
	logic [47:0] queue_mem [32];
	logic [4:0]  wr_ptr;
	logic [4:0]  rd_ptr;
	logic [5:0]  count;
	logic        queue_overrun_flag;
	logic        triggered;
	logic        int2_meta;
	logic        int2_sync;
	logic        zone_prev;
	logic        move_hold;

	wire accel_pkg::queue_mode_e queue_mode_sel = accel_pkg::queue_mode_e'(fifo_control[`FM_MSB:`FM_LSB]);
	wire        trigger_source_sel = fifo_control[`TR_BIT];
	wire [4:0]  watermark_threshold = fifo_control[`FTH_MSB:0];
	wire        fifo_en = core_control[`FIFO_EN_BIT];
	wire        byte_order_sel = core_control[`BLE_BIT];
	wire accel_pkg::int_mode_e int_mode =
		accel_pkg::int_mode_e'({int_one_config[`AOI_BIT], int_one_config[`SIXD_BIT]});
	wire [5:0]  dir_en = int_one_config[`EN_MSB:0];

	wire        all_axes_new_data = &new_data;
	wire        fifo_act = fifo_en && queue_mode_sel != accel_pkg::BYPASS;
	wire        full = count == `QUEUE_DEPTH;
	wire        empty = count == 6'h00;
	wire        watermark_flag = count > {1'b0, watermark_threshold};
	wire [4:0]  unread_sample_count = full ? `UNREAD_MAX : count[4:0];
	wire        trig_event = trigger_source_sel ? int2_sync : first_interrupt_pin;
	wire        may_overwrite = queue_mode_sel == accel_pkg::STREAM ||
		(queue_mode_sel == accel_pkg::TRIGGER && !triggered);

	wire        wr_hit_ref = wr && addr == `REF_ADDR;
	wire        wr_hit_fctrl = wr && addr == `FCTRL_ADDR;
	wire        wr_hit_cfg = wr && addr == `INTCFG_ADDR && boot_done;
	wire        wr_hit_core = wr && addr == `CORE_CTRL_ADDR;
	wire        rd_axis = rd && addr >= `X_LOW_ADDR && addr <= `Z_HIGH_ADDR;
	wire [1:0]  rd_idx = 2'(addr[2:1] - 2'h0);
	wire [2:0]  axis_read = rd_axis ? 3'(3'h1 << addr[2:1] - 2'h0) : 3'h0;
	wire        retrieve = rd && addr == `Z_HIGH_ADDR;

	wire        pop = retrieve && fifo_act && !empty;
	wire        push = odr_tick && fifo_act && (!full || may_overwrite) && !(triggered && full);
	wire        drop_old = push && full && !pop;
	wire        use_queue = fifo_act && !empty;
	wire [47:0] head = queue_mem[rd_ptr];
	wire [15:0] shown = use_queue ? head[16*rd_idx +: 16] : axis_val[rd_idx];
	wire [7:0]  shown_low = shown[7:0];
	wire [7:0]  shown_high = shown[15:8];
	wire        hi_sel = addr[0] ^ byte_order_sel;
	wire [2:0]  next_new_data = (new_data & ~axis_read) | sample_we;
	wire [2:0]  next_axis_overrun = axis_overrun | (sample_we & new_data);

	wire [5:0]  hits = axis_events & dir_en;
	wire        zone_known = |hits;
	wire        any_or = |hits;
	wire        all_and = (dir_en != 6'h00) && ((axis_events | ~dir_en) == 6'h3F);
	logic       next_int;

	always_comb begin
		case (int_mode)
			accel_pkg::OR_COMB:  next_int = any_or;
			accel_pkg::AND_COMB: next_int = all_and;
			accel_pkg::SIX_MOVE: next_int = move_hold || (zone_known && !zone_prev);
			accel_pkg::SIX_POS:  next_int = zone_known;
			default:             next_int = 1'b0;
		endcase
	end

	logic [7:0] rd_word;
	always_comb begin
		case (addr)
			`REF_ADDR:       rd_word = reference_value;
			`STATUS_ADDR:    rd_word = {all_axes_overrun, axis_overrun[2], axis_overrun[1], axis_overrun[0],
				all_axes_new_data, new_data[2], new_data[1], new_data[0]};
			`X_LOW_ADDR, `X_HIGH_ADDR, `Y_LOW_ADDR, `Y_HIGH_ADDR, `Z_LOW_ADDR, `Z_HIGH_ADDR:
				rd_word = pick_byte(shown, hi_sel);
			`FCTRL_ADDR:     rd_word = fifo_control;
			`FSRC_ADDR:      rd_word = {watermark_flag, queue_overrun_flag, empty, unread_sample_count};
			`INTCFG_ADDR:    rd_word = int_one_config;
			`CORE_CTRL_ADDR: rd_word = core_control;
			default:         rd_word = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reference_value <= `REF_RESET;
			fifo_control <= `FCTRL_RESET;
			core_control <= `CORE_CTRL_RESET;
			rdata <= 8'h00;
		end else begin
			if (wr_hit_ref)
				reference_value <= wdata;
			if (wr_hit_fctrl)
				fifo_control <= wdata;
			if (wr_hit_core)
				core_control <= wdata;
			rdata <= rd ? rd_word : 8'h00;
		end
	end

	// Boot keeps reloading the configuration so a host write before boot end has no effect.
	always_ff @(posedge clk) begin
		if (rst)
			int_one_config <= `INTCFG_RESET;
		else if (!boot_done)
			int_one_config <= boot_cfg;
		else if (wr_hit_cfg)
			int_one_config <= wdata;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			new_data <= 3'h0;
			axis_overrun <= 3'h0;
			all_axes_overrun <= 1'b0;
		end else begin
			new_data <= next_new_data;
			// A read clears the overrun flags, but a new overrun in the same cycle wins.
			axis_overrun <= next_axis_overrun & ~(axis_read & ~(sample_we & new_data));
			if (sample_we == 3'h7 && all_axes_new_data)
				all_axes_overrun <= 1'b1;
			else if (retrieve)
				all_axes_overrun <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sample_we[0])
			axis_val[0] <= x_sample;
		if (sample_we[1])
			axis_val[1] <= y_sample;
		if (sample_we[2])
			axis_val[2] <= z_sample;
		if (push)
			queue_mem[wr_ptr] <= {axis_val[2], axis_val[1], axis_val[0]};
	end

	always_ff @(posedge clk) begin
		if (rst || !fifo_act) begin
			wr_ptr <= 5'h00;
			rd_ptr <= 5'h00;
			count <= 6'h00;
		end else begin
			wr_ptr <= wr_ptr + 5'(push);
			rd_ptr <= rd_ptr + 5'(pop || drop_old);
			count <= bump(count, push && !drop_old, pop);
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !fifo_act)
			queue_overrun_flag <= 1'b0;
		// The first retrieved set clears the flag even when it is taken from a full queue.
		else if (full && !pop)
			queue_overrun_flag <= 1'b1;
		else if (pop)
			queue_overrun_flag <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst || queue_mode_sel != accel_pkg::TRIGGER)
			triggered <= 1'b0;
		else if (trig_event)
			triggered <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			int2_meta <= 1'b0;
			int2_sync <= 1'b0;
			zone_prev <= 1'b0;
			move_hold <= 1'b0;
			first_interrupt_pin <= 1'b0;
		end else begin
			int2_meta <= second_interrupt_pin;
			int2_sync <= int2_meta;
			zone_prev <= zone_known;
			if (zone_known && !zone_prev)
				move_hold <= 1'b1;
			else if (odr_tick)
				move_hold <= 1'b0;
			first_interrupt_pin <= next_int;
		end
	end

	sequence read_axis_s;
		rd_axis;
	endsequence

	ref_reset_a: assert property (@(posedge clk) rst |=> reference_value == 8'h00)
		else $error("Reference value not zero after reset.");

	set_overrun_a: assert property (@(posedge clk) disable iff (rst)
		sample_we == 3'h7 && all_axes_new_data |=> all_axes_overrun)
		else $error("All-axes overrun missed.");

	axis_overrun_a: assert property (@(posedge clk) disable iff (rst)
		sample_we[0] && new_data[0] |=> axis_overrun[0])
		else $error("X overrun missed.");

	new_set_a: assert property (@(posedge clk) disable iff (rst)
		sample_we == 3'h7 && !rd_axis |=> all_axes_new_data)
		else $error("New set not flagged.");

	read_clear_a: assert property (@(posedge clk) disable iff (rst)
		read_axis_s ##0 (sample_we == 3'h0) |=> !new_data[$past(rd_idx)])
		else $error("Axis flag survived a read.");

	count_limit_a: assert property (@(posedge clk) disable iff (rst)
		count <= `QUEUE_DEPTH)
		else $error("Queue count beyond depth.");

	count_step_a: assert property (@(posedge clk) disable iff (rst)
		fifo_act && push && !pop && !full ##1 fifo_act |-> count == $past(count) + 6'h01)
		else $error("Queue count did not rise.");

	queue_ovr_a: assert property (@(posedge clk) disable iff (rst)
		fifo_act && full && !pop |=> queue_overrun_flag || !fifo_act)
		else $error("Queue overrun not flagged when full.");

	disabled_a: assert property (@(posedge clk) disable iff (rst)
		!fifo_en |=> count == 6'h00)
		else $error("Queue holds data while disabled.");

	boot_lock_a: assert property (@(posedge clk) disable iff (rst)
		!rst && !boot_done |=> int_one_config == $past(boot_cfg))
		else $error("Configuration not loaded during boot.");

	position_a: assert property (@(posedge clk) disable iff (rst)
		int_mode == accel_pkg::SIX_POS && zone_known |=> first_interrupt_pin)
		else $error("Position interrupt dropped.");

	or_mode_a: assert property (@(posedge clk) disable iff (rst)
		int_mode == accel_pkg::OR_COMB && hits == 6'h00 |=> !first_interrupt_pin)
		else $error("OR interrupt with no enabled event.");

	sequence pop_only_s;
		fifo_act && pop && !push;
	endsequence

	sequence zone_entry_s;
		int_mode == accel_pkg::SIX_MOVE && zone_known && !zone_prev;
	endsequence

	ref_write_a: assert property (@(posedge clk) disable iff (rst)
		wr_hit_ref |=> reference_value == $past(wdata))
		else $error("Reference write lost.");

	z_overrun_a: assert property (@(posedge clk) disable iff (rst)
		sample_we[2] && new_data[2] |=> axis_overrun[2])
		else $error("Z overrun missed.");

	axis_flag_a: assert property (@(posedge clk) disable iff (rst)
		sample_we[1] |=> new_data[1])
		else $error("Y new-data flag missed.");

	queue_reset_a: assert property (@(posedge clk) rst |=> fifo_control == `FCTRL_RESET)
		else $error("Queue control not cleared by reset.");

	bypass_a: assert property (@(posedge clk) disable iff (rst)
		queue_mode_sel == accel_pkg::BYPASS |=> count == 6'h00)
		else $error("Queue filled in bypass mode.");

	trigger_set_a: assert property (@(posedge clk) disable iff (rst)
		queue_mode_sel == accel_pkg::TRIGGER && trig_event |=> triggered)
		else $error("Trigger event not latched.");

	wm_full_a: assert property (@(posedge clk) disable iff (rst)
		full |-> watermark_flag)
		else $error("Watermark flag low with a full queue.");

	overwrite_a: assert property (@(posedge clk) disable iff (rst)
		drop_old |=> full && rd_ptr == $past(rd_ptr) + 5'h01)
		else $error("Oldest set not dropped on overwrite.");

	ovr_clear_a: assert property (@(posedge clk) disable iff (rst)
		pop |=> !queue_overrun_flag)
		else $error("Queue overrun survived a retrieve.");

	empty_set_a: assert property (@(posedge clk) disable iff (rst)
		count == 6'h01 && pop && !push |=> empty)
		else $error("Queue not empty after last retrieve.");

	count_fall_a: assert property (@(posedge clk) disable iff (rst)
		pop_only_s ##1 fifo_act |-> count == $past(count) - 6'h01)
		else $error("Queue count did not fall.");

	cfg_reset_a: assert property (@(posedge clk) rst |=> int_one_config == `INTCFG_RESET)
		else $error("Interrupt enables not cleared by reset.");

	and_mode_a: assert property (@(posedge clk) disable iff (rst)
		int_mode == accel_pkg::AND_COMB && dir_en != 6'h00 && hits == dir_en |=> first_interrupt_pin)
		else $error("AND interrupt missed.");

	move_pulse_a: assert property (@(posedge clk) disable iff (rst)
		zone_entry_s |=> first_interrupt_pin)
		else $error("Movement interrupt missed.");

	move_hold_a: assert property (@(posedge clk) disable iff (rst)
		zone_entry_s ##1 (int_mode == accel_pkg::SIX_MOVE && !odr_tick) |=> first_interrupt_pin)
		else $error("Movement interrupt ended early.");

	pos_drop_a: assert property (@(posedge clk) disable iff (rst)
		int_mode == accel_pkg::SIX_POS && !zone_known |=> !first_interrupt_pin)
		else $error("Position interrupt outside a known zone.");

	byte_order_a: assert property (@(posedge clk) disable iff (rst)
		rd && addr == `X_LOW_ADDR |=> rdata == ($past(byte_order_sel) ? $past(shown_high) : $past(shown_low)))
		else $error("Axis byte order wrong.");

endmodule
`default_nettype wire

// ===== host_model.sv
// Host processor model that reaches the accelerometer registers over the plain bus.
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input  wire logic       clk,   // Bus clock
	input  wire logic [7:0] rdata, // Read data from the bank
	output logic      [7:0] addr,  // Register address
	output logic      [7:0] wdata, // Write data
	output logic            wr,    // Write strobe
	output logic            rd     // Read strobe
);
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// Data is inverted after a write and the address after a read, so that stale values are never mistaken for a request.
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		@(posedge clk);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the accelerometer register bank.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk, rst, wr, rd, odr_tick, boot_done, second_interrupt_pin, first_interrupt_pin;
	logic [7:0]  addr, wdata, rdata, boot_cfg, v;
	logic [2:0]  sample_we;
	logic [15:0] x_sample, y_sample, z_sample;
	logic [5:0]  axis_events;
	int          n_fail, checked;

	host_model host_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	accel_status_fifo_int_regs accel_status_fifo_int_regs_i (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .odr_tick(odr_tick), .sample_we(sample_we),
		.x_sample(x_sample), .y_sample(y_sample), .z_sample(z_sample), .axis_events(axis_events),
		.boot_done(boot_done), .boot_cfg(boot_cfg), .second_interrupt_pin(second_interrupt_pin),
		.first_interrupt_pin(first_interrupt_pin));

	always #10 clk = ~clk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host_model_i.read(a, v);
		chk(v, exp);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		host_model_i.write(a, d);
	endtask
	// One sample set on all three axes, then one output-rate tick.
	task automatic push(input logic [15:0] x);
		@(posedge clk);
		x_sample <= x;
		y_sample <= ~x;
		z_sample <= x + 16'h0100;
		sample_we <= 3'h7;
		@(posedge clk);
		sample_we <= 3'h0;
		odr_tick <= 1'b1;
		@(posedge clk);
		odr_tick <= 1'b0;
	endtask
	task automatic ichk(input logic [5:0] ev, input logic exp);
		@(posedge clk);
		axis_events <= ev;
		repeat (2) @(posedge clk);
		chk({7'h00, first_interrupt_pin}, {7'h00, exp});
	endtask

	task automatic t_reset();
		rchk(8'h26, 8'h00);
		rchk(8'h27, 8'h00);
		rchk(8'h2E, 8'h00);
		rchk(8'h40, 8'h00);
		rchk(8'h30, 8'h3F);
		wreg(8'h26, 8'hA5);
		rchk(8'h26, 8'hA5);
		rchk(8'h10, 8'h00);
		wreg(8'h30, 8'h00);
		rchk(8'h30, 8'h3F);
	endtask
	task automatic t_status();
		push(16'h8123);
		rchk(8'h27, 8'h0F);
		push(16'h8123);
		rchk(8'h27, 8'hFF);
		rchk(8'h28, 8'h23);
		rchk(8'h29, 8'h81);
		host_model_i.read(8'h27, v);
		chk(v & 8'h77, 8'h66);
		wreg(8'h40, 8'h02);
		rchk(8'h2A, 8'h7E);
		rchk(8'h2B, 8'hDC);
		wreg(8'h40, 8'h00);
		rchk(8'h2C, 8'h23);
		rchk(8'h2D, 8'h82);
		host_model_i.read(8'h27, v);
		chk(v & 8'hF7, 8'h00);
	endtask
	task automatic t_fifo();
		int i;
		wreg(8'h40, 8'h01);
		wreg(8'h2E, 8'h43);
		for (i = 0; i < 3; i++) push(16'(i));
		rchk(8'h2F, 8'h03);
		push(16'h0003);
		rchk(8'h2F, 8'h84);
		for (i = 4; i < 33; i++) push(16'(i));
		rchk(8'h2F, 8'hDF);
		rchk(8'h28, 8'h00);
		host_model_i.read(8'h2D, v);
		rchk(8'h2F, 8'h9F);
		rchk(8'h28, 8'h01);
		for (i = 0; i < 31; i++) host_model_i.read(8'h2D, v);
		rchk(8'h2F, 8'h20);
	endtask
	task automatic t_modes();
		int i;
		wreg(8'h2E, 8'h00);
		push(16'h0055);
		rchk(8'h2F, 8'h20);
		wreg(8'h2E, 8'h80);
		for (i = 0; i < 34; i++) push(16'(i));
		rchk(8'h28, 8'h02);
		rchk(8'h2F, 8'hDF);
		wreg(8'h2E, 8'h00);
		wreg(8'h2E, 8'hE0);
		for (i = 0; i < 34; i++) push(16'(i));
		rchk(8'h28, 8'h02);
		second_interrupt_pin <= 1'b1;
		repeat (4) @(posedge clk);
		push(16'h0022);
		push(16'h0023);
		rchk(8'h28, 8'h02);
		second_interrupt_pin <= 1'b0;
		wreg(8'h2E, 8'h00);
		wreg(8'h2E, 8'hC0);
		for (i = 0; i < 34; i++) push(16'(i));
		axis_events <= 6'h01;
		repeat (3) @(posedge clk);
		push(16'h0022);
		rchk(8'h28, 8'h02);
		axis_events <= 6'h00;
		wreg(8'h40, 8'h00);
		wreg(8'h2E, 8'h80);
		push(16'h0024);
		rchk(8'h2F, 8'h20);
	endtask
	task automatic t_int();
		wreg(8'h30, 8'h03);
		ichk(6'h01, 1'b1);
		ichk(6'h04, 1'b0);
		wreg(8'h30, 8'h83);
		ichk(6'h01, 1'b0);
		ichk(6'h03, 1'b1);
		wreg(8'h30, 8'hC3);
		ichk(6'h01, 1'b1);
		repeat (5) @(posedge clk);
		chk({7'h00, first_interrupt_pin}, 8'h01);
		ichk(6'h00, 1'b0);
		wreg(8'h30, 8'h43);
		ichk(6'h01, 1'b1);
		@(posedge clk);
		odr_tick <= 1'b1;
		@(posedge clk);
		odr_tick <= 1'b0;
		ichk(6'h01, 1'b0);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		odr_tick = 1'b0;
		sample_we = 3'h0;
		x_sample = 16'h0000;
		y_sample = 16'h0000;
		z_sample = 16'h0000;
		axis_events = 6'h00;
		boot_done = 1'b0;
		boot_cfg = 8'h3F;
		second_interrupt_pin = 1'b0;
		n_fail = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		// Boot finishes here; the interrupt configuration write in t_reset came before boot end and had no effect.
		boot_done <= 1'b1;
		t_status();
		t_fifo();
		t_modes();
		t_int();
		results();
	end
	initial begin
		#200000;
		n_fail++;
		results();
	end
endmodule
`default_nettype wire
